/* File: verilog/vdl_pkg.sv */
// Package for the voice converter load control block.
// Assumes a 32-bit APB slave at 20 MHz and no other users.
package vdl_pkg;
   // Register byte addresses (word aligned)
   localparam logic [11:0] VDL_OFF_DATA_HIGH = 12'h000;
   localparam logic [11:0] VDL_OFF_DATA_LOW  = 12'h004;
   localparam logic [11:0] VDL_OFF_CONTROL   = 12'h008;
   localparam logic [11:0] VDL_OFF_STATUS    = 12'h00c;
   // Field positions
   localparam int VDL_CTRL_ON_BIT   = 0;
   localparam int VDL_STAT_RDY_BIT  = 0;
   localparam int VDL_STAT_BUSY_BIT = 1;
   // Reset values
   localparam logic [7:0] VDL_BYTE_RESET = 8'h00;
   localparam logic       VDL_ON_RESET   = 1'b0;
   // Settling time, figure and derived cycle count at 20 MHz
   localparam int VDL_CLK_HZ         = 20000000;
   localparam int VDL_SETTLE_NS      = 10000;
   localparam int VDL_SETTLE_CYC_RAW =
      (VDL_SETTLE_NS * (VDL_CLK_HZ / 1000000) + 999) / 1000;
   localparam int VDL_SETTLE_CYC     =
      (VDL_SETTLE_CYC_RAW < 1) ? 1 : VDL_SETTLE_CYC_RAW;
   localparam int VDL_CNT_W = 16;
   // Conversion busy window length in cycles
   localparam logic [3:0] VDL_CONV_CYC = 4'h4;
   // Control states of the converter
   typedef enum logic [1:0] {VDL_OFF, VDL_SETTLING, VDL_READY} vdl_state_e;
endpackage

/* File: verilog/vdl_settle.sv */
// Settling timer: counts after the enable goes high.
// Assumes enable is a registered level in the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module vdl_settle
   import vdl_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic resetn,
   // Control
   input  wire logic enable,
   // Status
   output var  logic ready
);
   logic [VDL_CNT_W-1:0] cnt_reg, cnt_next;
   logic                 rdy_reg, rdy_next;
   localparam logic [VDL_CNT_W-1:0] LAST = VDL_CNT_W'(VDL_SETTLE_CYC - 1);

   // Restart on every disable so a re-enable waits the full time
   always_comb begin
      cnt_next = cnt_reg;
      rdy_next = rdy_reg;
      if (!enable) begin
         cnt_next = '0;
         rdy_next = 1'b0;
      end else if (!rdy_reg) begin
         if (cnt_reg == LAST) begin
            rdy_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= '0;
         rdy_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         rdy_reg <= rdy_next;
      end
   end

   assign ready = rdy_reg;
endmodule
`default_nettype wire

/* File: verilog/vdl_conv.sv */
// Conversion start generator: stretches a load into a busy window.
// Assumes load is a one-cycle pulse from the register block.
`timescale 1ns/1ns
`default_nettype none
module vdl_conv
   import vdl_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic resetn,
   // Request
   input  wire logic load,
   // Status
   output var  logic busy
);
   logic [3:0] cnt_reg, cnt_next;

   // A new load restarts the window, never queues
   always_comb begin
      cnt_next = cnt_reg;
      if (load) begin
         cnt_next = VDL_CONV_CYC;
      end else if (cnt_reg != 4'h0) begin
         cnt_next = cnt_reg - 4'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= 4'h0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign busy = (cnt_reg != 4'h0);
endmodule
`default_nettype wire

/* File: verilog/vdl_top.sv */
// Register block and load control of the 16-bit voice converter.
// Assumes an APB master on ref_clk; converter is analog, outside.
//
// Contract
// - Low byte write only fills the shadow buffer, converter word unchanged.
// - High byte write copies shadow buffer into the low byte register.
// - Each high byte write with lane 0 on loads the full word and starts conversion.
// - Control bit 0 enables the converter; zero disables it.
// - Control bits seven to one read zero, writes ignored.
// - High register holds bits 15..8, low holds 7..0; both read back, but low is written only through the shadow.
`timescale 1ns/1ns
`default_nettype none
module vdl_top
   import vdl_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // Converter side
   output var  logic [15:0] dac_word,
   output var  logic        dac_load,
   output var  logic        converter_on
);
   logic [7:0]  high_reg, high_next;
   logic [7:0]  low_reg, low_next;
   logic [7:0]  shadow_reg, shadow_next;
   logic        on_reg, on_next;
   logic [15:0] word_reg, word_next;
   logic        load_reg, load_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        rdy_reg, rdy_next;
   logic        err_reg, err_next;
   logic        settled;
   logic        busy;
   logic        acc;
   logic        wr;
   logic        lane0;
   logic        hit;

   // Single-cycle access phase; ready is registered so it lands one later
   assign acc   = psel && penable && !rdy_reg;
   assign wr    = acc && pwrite;
   assign lane0 = pstrb[0];

   vdl_settle u_settle (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .enable  (on_reg),
      .ready   (settled)
   );

   vdl_conv u_conv (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .load    (load_reg),
      .busy    (busy)
   );

   // Register writes and converter load
   always_comb begin
      high_next   = high_reg;
      low_next    = low_reg;
      shadow_next = shadow_reg;
      on_next     = on_reg;
      word_next   = word_reg;
      load_next   = 1'b0;
      if (wr && lane0) begin
         if (paddr == VDL_OFF_DATA_HIGH) begin
            high_next = pwdata[7:0];
            low_next  = shadow_reg;
            word_next = {pwdata[7:0], shadow_reg};
            load_next = 1'b1;
         end else if (paddr == VDL_OFF_DATA_LOW) begin
            shadow_next = pwdata[7:0];
         end else if (paddr == VDL_OFF_CONTROL) begin
            on_next = pwdata[VDL_CTRL_ON_BIT];
         end
      end
   end

   // Read mux and slave answer; unmapped addresses error
   always_comb begin
      rdata_next = 32'h0000_0000;
      rdy_next   = acc;
      err_next   = 1'b0;
      hit        = 1'b1;
      if (paddr == VDL_OFF_DATA_HIGH) begin
         rdata_next[7:0] = high_reg;
      end else if (paddr == VDL_OFF_DATA_LOW) begin
         rdata_next[7:0] = low_reg;
      end else if (paddr == VDL_OFF_CONTROL) begin
         rdata_next[VDL_CTRL_ON_BIT] = on_reg;
      end else if (paddr == VDL_OFF_STATUS) begin
         rdata_next[VDL_STAT_RDY_BIT]  = settled;
         rdata_next[VDL_STAT_BUSY_BIT] = busy;
      end else begin
         hit = 1'b0;
      end
      if (!acc || pwrite) begin
         rdata_next = 32'h0000_0000;
      end
      err_next = acc && !hit;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         high_reg   <= VDL_BYTE_RESET;
         low_reg    <= VDL_BYTE_RESET;
         shadow_reg <= VDL_BYTE_RESET;
         on_reg     <= VDL_ON_RESET;
         word_reg   <= 16'h0000;
         load_reg   <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rdy_reg    <= 1'b0;
         err_reg    <= 1'b0;
      end else begin
         high_reg   <= high_next;
         low_reg    <= low_next;
         shadow_reg <= shadow_next;
         on_reg     <= on_next;
         word_reg   <= word_next;
         load_reg   <= load_next;
         rdata_reg  <= rdata_next;
         rdy_reg    <= rdy_next;
         err_reg    <= err_next;
      end
   end

   assign prdata       = rdata_reg;
   assign pready       = rdy_reg;
   assign pslverr      = err_reg;
   assign dac_word     = word_reg;
   assign dac_load     = load_reg;
   assign converter_on = on_reg;

   // Checks
   a_low_no_load: assert property (@(posedge ref_clk) disable iff (!resetn)
      (wr && lane0 && paddr == VDL_OFF_DATA_LOW) |=>
      $stable(word_reg) && !load_reg)
      else $error("low byte write changed converter word");
   a_high_copy: assert property (@(posedge ref_clk) disable iff (!resetn)
      (wr && lane0 && paddr == VDL_OFF_DATA_HIGH) |=>
      low_reg == $past(shadow_reg))
      else $error("shadow not copied to low byte");
   a_high_load: assert property (@(posedge ref_clk) disable iff (!resetn)
      (wr && lane0 && paddr == VDL_OFF_DATA_HIGH) |=>
      dac_load && dac_word == {$past(pwdata[7:0]), $past(shadow_reg)}
      ##1 !dac_load)
      else $error("high byte write did not load word");
   a_load_cause: assert property (@(posedge ref_clk) disable iff (!resetn)
      dac_load |-> $past(wr) && $past(paddr) == VDL_OFF_DATA_HIGH)
      else $error("load without high byte write");
   a_enable_bit: assert property (@(posedge ref_clk) disable iff (!resetn)
      (wr && lane0 && paddr == VDL_OFF_CONTROL) |=>
      converter_on == $past(pwdata[0]))
      else $error("enable bit not taken from bit 0");
   a_ctrl_upper: assert property (@(posedge ref_clk) disable iff (!resetn)
      (acc && !pwrite && paddr == VDL_OFF_CONTROL) |=>
      prdata[31:1] == 31'h0 && pready)
      else $error("control upper bits not zero");
   a_read_bytes: assert property (@(posedge ref_clk) disable iff (!resetn)
      (acc && !pwrite && paddr == VDL_OFF_DATA_HIGH) |=>
      prdata == {24'h0, dac_word[15:8]} || $past(dac_load))
      else $error("high byte read mismatch");
   a_reset_clear: assert property (@(posedge ref_clk)
      $rose(resetn) |-> !converter_on && dac_word == 16'h0
      && low_reg == 8'h0 && shadow_reg == 8'h0)
      else $error("reset did not clear state");
   c_high_write: cover property (@(posedge ref_clk) disable iff (!resetn)
      dac_load);
   c_settled: cover property (@(posedge ref_clk) disable iff (!resetn)
      $rose(settled));
   c_bad_addr: cover property (@(posedge ref_clk) disable iff (!resetn)
      pslverr);

   // Status read while a conversion window is open
   c_status_busy: cover property (@(posedge ref_clk) disable iff (!resetn)
      acc && !pwrite && paddr == VDL_OFF_STATUS && busy);

   // Write with lane 0 off, which must be dropped
   c_strobe_off: cover property (@(posedge ref_clk) disable iff (!resetn)
      wr && !lane0);

   // Low byte write lands in the shadow and leaves the low register
   a_shadow_fill: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      (wr && lane0 && paddr == VDL_OFF_DATA_LOW) |=>
      shadow_reg == $past(pwdata[7:0]) && $stable(low_reg))
      else $error("low byte write missed the shadow");

   // Shadow only moves on a low byte write
   a_shadow_keep: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      !(wr && lane0 && paddr == VDL_OFF_DATA_LOW) |=>
      $stable(shadow_reg))
      else $error("shadow changed without a low byte write");

   // High byte register takes the written byte
   a_high_reg: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      (wr && lane0 && paddr == VDL_OFF_DATA_HIGH) |=>
      high_reg == $past(pwdata[7:0]))
      else $error("high byte register not written");

   // Converter word only moves together with a load pulse
   a_word_stable: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      !dac_load |-> $stable(dac_word))
      else $error("converter word moved without a load");

   // Every load opens a conversion window
   a_busy_after: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      dac_load |=> busy)
      else $error("load did not start a conversion");

   // Clearing bit 0 turns the converter off
   a_enable_off: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      (wr && lane0 && paddr == VDL_OFF_CONTROL && !pwdata[0]) |=>
      !converter_on)
      else $error("converter stayed on after clear");

   // Control read returns the enable bit in bit 0
   a_ctrl_read: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      (acc && !pwrite && paddr == VDL_OFF_CONTROL) |=>
      prdata[0] == $past(on_reg))
      else $error("control read lost the enable bit");

   // Low byte read returns the committed byte, zero above
   a_low_read: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      (acc && !pwrite && paddr == VDL_OFF_DATA_LOW) |=>
      prdata == {24'h0, $past(low_reg)})
      else $error("low byte read mismatch");

   // Lane 0 off: nothing may change or load
   a_strb_ignore: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      (wr && !lane0) |=>
      $stable(word_reg) && $stable(on_reg) && !load_reg)
      else $error("write with lane 0 off took effect");

   // Status is read only; a write there must not act
   a_status_ro: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      (wr && lane0 && paddr == VDL_OFF_STATUS) |=>
      $stable(on_reg) && !load_reg)
      else $error("write to status took effect");

   // Settled flag drops one cycle after the converter is off
   a_settle_off: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      !converter_on |=> !settled)
      else $error("settled while converter off");

   // Unmapped addresses answer with an error
   a_err_unmap: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      (acc && paddr != VDL_OFF_DATA_HIGH && paddr != VDL_OFF_DATA_LOW
      && paddr != VDL_OFF_CONTROL && paddr != VDL_OFF_STATUS) |=>
      pslverr && pready)
      else $error("unmapped access without error");

   // The answer is a single-cycle pulse
   a_ready_pulse: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      pready |=> !pready)
      else $error("pready held longer than one cycle");

   // Error only ever comes with the answer
   a_err_ready: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      pslverr |-> pready)
      else $error("pslverr without pready");

   // Read bus stays quiet outside an answer
   a_rdata_idle: assert property (@(posedge ref_clk)
      disable iff (!resetn)
      !pready |-> prdata == 32'h0000_0000)
      else $error("read data driven outside an answer");
endmodule
`default_nettype wire

/* File: bench/vdl_top_bench.sv */
// Self-checking bench for the voice converter load control block.
// Assumes vdl_pkg and vdl_top compiled first; bench acts as APB master.
`timescale 1ns/1ns
`default_nettype none
module vdl_top_bench
   import vdl_pkg::*;
;
   logic        ref_clk;
   logic        resetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [15:0] dac_word;
   logic        dac_load;
   logic        converter_on;
   logic [31:0] rd_data;
   logic        rd_err;
   int          err_total;
   int          cmp_count;
   int          load_cnt;

   vdl_top DUT (
      .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dac_word(dac_word), .dac_load(dac_load),
      .converter_on(converter_on)
   );

   // 20 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Count load pulses on the falling edge, clear of the launch race
   always @(negedge ref_clk) begin
      if (dac_load === 1'b1) load_cnt++;
   end

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer; held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Look at settled outputs mid-cycle; prdata and pslverr are sampled on the first falling edge with pready high
      @(negedge ref_clk);
      while (pready !== 1'b1) @(negedge ref_clk);
      rd_data = prdata;
      rd_err  = pslverr;
      @(posedge ref_clk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd_data, exp);
   endtask

   // Watchdog: the sequence needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge ref_clk);
      err_total++;
      close_out();
   end

   initial begin
      err_total = 0;
      cmp_count = 0;
      load_cnt  = 0;
      resetn  = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
      pstrb   = 4'hf;
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      // Reset state of registers and converter outputs
      rd_chk(VDL_OFF_DATA_HIGH, 32'h0000_0000);
      rd_chk(VDL_OFF_DATA_LOW, 32'h0000_0000);
      rd_chk(VDL_OFF_CONTROL, 32'h0000_0000);
      chk({16'h0000, dac_word}, 32'h0000_0000);
      chk({31'h0, converter_on}, 32'h0000_0000);
      // Enable with all bits set; only bit 0 may stick
      apb(1'b1, VDL_OFF_CONTROL, 32'h0000_00ff);
      rd_chk(VDL_OFF_CONTROL, 32'h0000_0001);
      chk({31'h0, converter_on}, 32'h0000_0001);
      // Software waits out the settling time before data
      repeat (VDL_SETTLE_CYC + 10) @(posedge ref_clk);
      rd_chk(VDL_OFF_STATUS, 32'h0000_0001);
      apb(1'b1, VDL_OFF_DATA_LOW, 32'h0000_00a5);
      rd_chk(VDL_OFF_DATA_LOW, 32'h0000_0000);
      chk({16'h0000, dac_word}, 32'h0000_0000);
      chk(32'(load_cnt), 32'h0000_0000);
      apb(1'b1, VDL_OFF_DATA_HIGH, 32'h0000_003c);
      // Conversion window still open: settled and busy
      rd_chk(VDL_OFF_STATUS, 32'h0000_0003);
      rd_chk(VDL_OFF_DATA_LOW, 32'h0000_00a5);
      rd_chk(VDL_OFF_DATA_HIGH, 32'h0000_003c);
      chk({16'h0000, dac_word}, 32'h0000_3ca5);
      chk(32'(load_cnt), 32'h0000_0001);
      // Back-to-back high writes reuse the shadow low byte
      apb(1'b1, VDL_OFF_DATA_HIGH, 32'h0000_00ff);
      apb(1'b1, VDL_OFF_DATA_HIGH, 32'h0000_00ff);
      chk({16'h0000, dac_word}, 32'h0000_ffa5);
      chk(32'(load_cnt), 32'h0000_0003);
      // Write with lane 0 off must be ignored
      pstrb <= 4'he;
      apb(1'b1, VDL_OFF_DATA_HIGH, 32'h0000_0077);
      pstrb <= 4'hf;
      chk({16'h0000, dac_word}, 32'h0000_ffa5);
      chk(32'(load_cnt), 32'h0000_0003);
      // Reset in mid-run clears everything again
      @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      rd_chk(VDL_OFF_CONTROL, 32'h0000_0000);
      rd_chk(VDL_OFF_DATA_HIGH, 32'h0000_0000);
      chk({16'h0000, dac_word}, 32'h0000_0000);
      apb(1'b1, VDL_OFF_CONTROL, 32'h0000_0001);
      repeat (VDL_SETTLE_CYC + 10) @(posedge ref_clk);
      // Boundary word of all zeros after a nonzero low byte
      apb(1'b1, VDL_OFF_DATA_LOW, 32'h0000_005a);
      apb(1'b1, VDL_OFF_DATA_HIGH, 32'h0000_0000);
      chk({16'h0000, dac_word}, 32'h0000_005a);
      apb(1'b1, VDL_OFF_DATA_LOW, 32'h0000_0000);
      apb(1'b1, VDL_OFF_DATA_HIGH, 32'h0000_0000);
      rd_chk(VDL_OFF_DATA_LOW, 32'h0000_0000);
      chk({16'h0000, dac_word}, 32'h0000_0000);
      // Unmapped address answers with an error
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk({31'h0, rd_err}, 32'h0000_0001);
      // Clearing bit 0 disables; upper bits ignored
      apb(1'b1, VDL_OFF_CONTROL, 32'h0000_00fe);
      rd_chk(VDL_OFF_CONTROL, 32'h0000_0000);
      chk({31'h0, converter_on}, 32'h0000_0000);
      rd_chk(VDL_OFF_STATUS, 32'h0000_0000);
      close_out();
   end
endmodule
`default_nettype wire
